// ==== fcl_counter.v ====
// Frequency measurement channel: counts input edges per window, checks limits.
// Assumes all inputs synchronous to mclk and configuration held steady while gated.
`timescale 1ns/1ns
`include "fcl_defines.vh"

module fcl_counter #(
   parameter VW = 26,
   parameter CYC_PER_MS = `FCL_CYC_PER_MS
)(
   input wire mclk,
   input wire reset,
   input wire countIn,
   input wire directionIn,
   input wire [13:0] windowMs,
   input wire [VW-1:0] lowLimit,
   input wire [VW-1:0] highLimit,
   input wire [2:0] maxFreqSel,
   input wire averagedMode,
   input wire encoderMode,
   input wire invertDirection,
   input wire hardwareGateEnable,
   input wire software_start_gate,
   input wire hardware_start_gate,
   input wire [1:0] compareMode,
   input wire irqGateOpenEn,
   input wire irqGateCloseEn,
   input wire irqEndEn,
   input wire irqBelowEn,
   input wire irqAboveEn,
   output reg [VW-1:0] measuredValue,
   output reg below_low_limit_flag,
   output reg above_high_limit_flag,
   output reg countDown,
   output reg digitalOut,
   output reg measureDone,
   output reg interruptPulse
);

////////////////////////////////////////////////////////////////////////
// Edge filter: minimum high and low time of half the fastest period

function [15:0] halfPeriodCycles;
   input [2:0] sel;
   begin
      case (sel)
         `FCL_FMAX_60K: halfPeriodCycles = 16'h01a0;
         `FCL_FMAX_30K: halfPeriodCycles = 16'h0341;
         `FCL_FMAX_10K: halfPeriodCycles = 16'h09c4;
         `FCL_FMAX_5K: halfPeriodCycles = 16'h1388;
         `FCL_FMAX_2K: halfPeriodCycles = 16'h30d4;
         default: halfPeriodCycles = 16'h61a8;
      endcase
   end
endfunction

reg filtLevel_r;
reg [15:0] filtCnt_r;
reg filtPrev_r;
wire [15:0] filtLimit = halfPeriodCycles(maxFreqSel);

always @(posedge mclk)
begin
   if (reset)
   begin
      filtLevel_r <= 1'b0;
      filtCnt_r <= 16'h0000;
      filtPrev_r <= 1'b0;
   end
   else
   begin
      filtPrev_r <= filtLevel_r;
      if (countIn == filtLevel_r)
         filtCnt_r <= 16'h0000;
      else if (filtCnt_r >= filtLimit - 16'h0001)
      begin
         filtLevel_r <= countIn;
         filtCnt_r <= 16'h0000;
      end
      else
         filtCnt_r <= filtCnt_r + 16'h0001;
   end
end

wire countEdge = filtLevel_r & ~filtPrev_r;
wire dirLevel = directionIn ^ invertDirection;

////////////////////////////////////////////////////////////////////////
// Gate logic

wire gateOpen = software_start_gate & (hardware_start_gate | ~hardwareGateEnable);
reg hwPrev_r;
reg gatePrev_r;

////////////////////////////////////////////////////////////////////////
// Window timing and counting

reg [15:0] cycCnt_r;
reg [13:0] msCnt_r;
reg [15:0] edgeCnt_r;
reg [15:0] idleWins_r;
reg [VW-1:0] lastValue_r;
wire [13:0] winLen = (windowMs < `FCL_WIN_MS_MIN) ? `FCL_WIN_MS_MIN :
   (windowMs > `FCL_WIN_MS_MAX) ? `FCL_WIN_MS_MAX : windowMs;
wire msTick = (cycCnt_r == CYC_PER_MS - 1);
wire winEnd = gateOpen & msTick & (msCnt_r == winLen - 14'h0001);

// Edges per window to mHz: edges * 1000 * 1000 / windowMs
wire [47:0] scaled = edgeCnt_r * 48'd1000000;
// Quotient kept wide; the result fits VW bits within the documented ranges
wire [47:0] directWide = scaled / winLen;
wire [VW-1:0] directValue = directWide[VW-1:0];
wire [VW-1:0] avgValue = lastValue_r / (idleWins_r + 16'h0001);
reg [VW-1:0] newValue;

always @*
begin
   if (edgeCnt_r != 16'h0000)
      newValue = directValue;
   else if (!averagedMode)
      newValue = {VW{1'b0}};
   else if (avgValue == {VW{1'b0}} && lastValue_r != {VW{1'b0}})
      newValue = `FCL_AVG_FLOOR;
   else
      newValue = avgValue;
end

wire newBelow = newValue < lowLimit;
wire newAbove = newValue > highLimit;

always @(posedge mclk)
begin
   if (reset)
   begin
      cycCnt_r <= 16'h0000;
      msCnt_r <= 14'h0000;
      edgeCnt_r <= 16'h0000;
      idleWins_r <= 16'h0000;
      lastValue_r <= {VW{1'b0}};
      measuredValue <= {VW{1'b0}};
      below_low_limit_flag <= 1'b0;
      above_high_limit_flag <= 1'b0;
      countDown <= 1'b0;
      digitalOut <= 1'b0;
      measureDone <= 1'b0;
      interruptPulse <= 1'b0;
      hwPrev_r <= 1'b0;
      gatePrev_r <= 1'b0;
   end
   else
   begin
      hwPrev_r <= hardware_start_gate;
      gatePrev_r <= gateOpen;
      measureDone <= winEnd;
      interruptPulse <= (irqGateOpenEn & hardwareGateEnable & software_start_gate
            & hardware_start_gate & ~hwPrev_r)
         | (irqGateCloseEn & hardwareGateEnable & software_start_gate
            & ~hardware_start_gate & hwPrev_r)
         | (irqEndEn & winEnd)
         | (irqBelowEn & winEnd & newBelow & ~below_low_limit_flag)
         | (irqAboveEn & winEnd & newAbove & ~above_high_limit_flag);
      if (!gateOpen)
      begin
         cycCnt_r <= 16'h0000;
         msCnt_r <= 14'h0000;
         edgeCnt_r <= 16'h0000;
      end
      else
      begin
         if (!gatePrev_r)
            edgeCnt_r <= 16'h0000;
         cycCnt_r <= msTick ? 16'h0000 : cycCnt_r + 16'h0001;
         if (winEnd)
         begin
            msCnt_r <= 14'h0000;
            edgeCnt_r <= {15'h0000, countEdge};
            measuredValue <= newValue;
            below_low_limit_flag <= newBelow;
            above_high_limit_flag <= newAbove;
            if (edgeCnt_r != 16'h0000)
            begin
               lastValue_r <= directValue;
               idleWins_r <= 16'h0000;
            end
            else if (idleWins_r != 16'hffff)
               idleWins_r <= idleWins_r + 16'h0001;
            case (compareMode)
               `FCL_CMP_NONE: digitalOut <= 1'b0;
               `FCL_CMP_OUTSIDE: digitalOut <= newBelow | newAbove;
               `FCL_CMP_BELOW: digitalOut <= newBelow;
               `FCL_CMP_ABOVE: digitalOut <= newAbove;
               default: digitalOut <= 1'b0;
            endcase
         end
         else
         begin
            if (msTick)
               msCnt_r <= msCnt_r + 14'h0001;
            if (countEdge && edgeCnt_r != 16'hffff && gatePrev_r)
               edgeCnt_r <= edgeCnt_r + 16'h0001;
         end
      end
      // Encoder single evaluation: direction is inverted B level at A rising edge
      if (countEdge)
         countDown <= encoderMode ? ~dirLevel : dirLevel;
   end
end

endmodule // fcl_counter

// ==== fcl_counter_tb_top.sv ====
// Self-checking bench for fcl_counter with a pulse source model.
// Assumes a shortened millisecond (CYC_PER_MS 10) and 500 ms windows.
`timescale 1ns/1ns
module fcl_counter_tb_top;
   reg mclk = 1'b0, reset = 1'b1, directionIn = 1'b0, invertDirection = 1'b0, go = 1'b0, expCd = 1'b0;
   reg averagedMode = 1'b0, encoderMode = 1'b0, hardwareGateEnable = 1'b1;
   reg software_start_gate = 1'b0, hardware_start_gate = 1'b1;
   reg irqGateOpenEn = 1'b0, irqGateCloseEn = 1'b0, irqEndEn = 1'b0, irqBelowEn = 1'b0, irqAboveEn = 1'b0;
   reg [13:0] windowMs = 14'h01f4;
   reg [25:0] lowLimit = 26'h0000000, highLimit = 26'h0000001, expVal = 26'h0000000;
   reg [2:0] maxFreqSel = 3'h0, nReq = 3'h0;
   reg [1:0] compareMode = 2'h0;
   wire [25:0] measuredValue;
   wire countIn, below_low_limit_flag, above_high_limit_flag, countDown, digitalOut, measureDone, interruptPulse;
   integer seed, i, errorCnt = 0, nCompared = 0, cycles = 0, lastVal = 0, idleN = 0;
   reg expB = 1'b0, expA = 1'b0;
   always #10 mclk = ~mclk;
   fcl_pulse_src src_u (.mclk(mclk), .go(go), .nPulse(nReq), .pulse(countIn));
   fcl_counter #(.CYC_PER_MS(10)) dut_u (.*);
   ////////////////////////////////////////////////////////////////////////
   task cmp(input [25:0] got, input [25:0] exp);
   begin
      nCompared = nCompared + 1;
      if (got !== exp)
      begin
         errorCnt = errorCnt + 1;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task print_verdict;
   begin
      if (errorCnt == 0 && nCompared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 80000)
      begin
         errorCnt = errorCnt + 1;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 32'hb373;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      software_start_gate = 1'b1;
      for (i = 0; i < 12; i = i + 1)
      begin
         nReq = {$random(seed)} % 5;
         directionIn = $random(seed);
         invertDirection = i[2];
         {irqGateOpenEn, irqGateCloseEn, irqEndEn, irqBelowEn, irqAboveEn} = $random(seed);
         compareMode = i[1:0];
         averagedMode = i[3];
         encoderMode = i[0];
         lowLimit = {$random(seed)} % 9000;
         highLimit = lowLimit + 1 + {$random(seed)} % 4000;
         go = 1'b1;
         @(negedge mclk);
         go = 1'b0;
         do @(negedge mclk); while (measureDone !== 1'b1);
         // Each edge in a 500 ms window is worth 2000 mHz
         if (nReq != 3'h0)
         begin
            expVal = nReq * 2000;
            lastVal = expVal;
            idleN = 0;
            expCd = encoderMode ? ~(directionIn ^ invertDirection) : (directionIn ^ invertDirection);
         end
         else
         begin
            // Edgeless window: zero when direct, spread last value when averaged
            expVal = averagedMode ? lastVal / (idleN + 1) : 0;
            if (averagedMode && expVal == 0 && lastVal != 0)
               expVal = 1;
            idleN = idleN + 1;
         end
         cmp(measuredValue, expVal);
         cmp(below_low_limit_flag, expVal < lowLimit);
         cmp(above_high_limit_flag, expVal > highLimit);
         cmp(digitalOut, (compareMode[0] & expVal > highLimit) | (^compareMode & expVal < lowLimit));
         cmp(countDown, expCd);
         cmp(interruptPulse, irqEndEn | (irqBelowEn & (expVal < lowLimit) & ~expB)
            | (irqAboveEn & (expVal > highLimit) & ~expA));
         expB = expVal < lowLimit;
         expA = expVal > highLimit;
         // Limits stay put until the checker has seen the done pulse
         @(negedge mclk);
      end
      // Hardware gate closes alone; the burst must not reach the value
      nReq = 3'h4;
      go = 1'b1;
      irqGateCloseEn = 1'b1;
      hardware_start_gate = 1'b0;
      @(negedge mclk);
      go = 1'b0;
      cmp(interruptPulse, 1'b1);
      repeat (6000) @(negedge mclk);
      cmp(measuredValue, expVal);
      irqGateOpenEn = 1'b1;
      hardware_start_gate = 1'b1;
      @(negedge mclk);
      cmp(interruptPulse, 1'b1);
      print_verdict;
   end
endmodule // fcl_counter_tb_top

// ==== fcl_defines.vh ====
// Constants for the frequency counter with limits.
// Assumes a 50 MHz mclk; included by fcl_counter.v.
`ifndef FCL_DEFINES_VH
`define FCL_DEFINES_VH
`define FCL_CLK_HZ 50000000
`define FCL_CYC_PER_MS (`FCL_CLK_HZ / 1000)
`define FCL_WIN_MS_MIN 14'h0001
`define FCL_WIN_MS_MAX 14'h2710
`define FCL_WIN_MS_DEF 14'h0064
`define FCL_LOW_DEF 26'h0000000
`define FCL_HIGH_DEF 26'h3938700
`define FCL_CMP_NONE 2'h0
`define FCL_CMP_OUTSIDE 2'h1
`define FCL_CMP_BELOW 2'h2
`define FCL_CMP_ABOVE 2'h3
`define FCL_FMAX_60K 3'h0
`define FCL_FMAX_30K 3'h1
`define FCL_FMAX_10K 3'h2
`define FCL_FMAX_5K 3'h3
`define FCL_FMAX_2K 3'h4
`define FCL_FMAX_1K 3'h5
`define FCL_MHZ_PER_HZ 1000
`define FCL_AVG_FLOOR 26'h0000001
`endif

// ==== fcl_properties.sv ====
// Checker for fcl_counter: window pulses, limit flags, compare output.
// Assumes limits and compare mode stay steady around each window end.
`timescale 1ns/1ns
module fcl_properties #(
   parameter VW = 26,
   parameter CYC_PER_MS = 50000
)(
   input wire mclk,
   input wire reset,
   input wire software_start_gate,
   input wire [VW-1:0] lowLimit,
   input wire [VW-1:0] highLimit,
   input wire [1:0] compareMode,
   input wire irqEndEn,
   input wire [VW-1:0] measuredValue,
   input wire below_low_limit_flag,
   input wire above_high_limit_flag,
   input wire digitalOut,
   input wire measureDone,
   input wire interruptPulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   done_pulse_a: assert property (measureDone |=> !measureDone) else $error("done held");
   value_hold_a: assert property ($changed(measuredValue) |-> measureDone) else $error("value moved");
   gate_closed_a: assert property (!software_start_gate [*2] |=> !measureDone) else $error("gate ran");
   irq_end_a: assert property (measureDone && $past(irqEndEn) |-> interruptPulse) else $error("no irq");
   below_flag_a:
      assert property (measureDone |-> below_low_limit_flag == (measuredValue < lowLimit)) else $error("below");
   above_flag_a:
      assert property (measureDone |-> above_high_limit_flag == (measuredValue > highLimit)) else $error("above");
   dout_outside_a:
      assert property (measureDone && compareMode == 2'h1 |-> digitalOut == (below_low_limit_flag
         || above_high_limit_flag)) else $error("outside");
   dout_above_a:
      assert property (measureDone && compareMode == 2'h3 |-> digitalOut == above_high_limit_flag)
         else $error("above out");
endmodule // fcl_properties

bind fcl_counter fcl_properties #(.VW(VW), .CYC_PER_MS(CYC_PER_MS)) chk_u (.*);

// ==== fcl_pulse_src.sv ====
// Pulse source model: a burst of pulses on each request.
// Assumes go is raised for one cycle per burst.
`timescale 1ns/1ns
module fcl_pulse_src (
   input wire mclk,
   input wire go,
   input wire [2:0] nPulse,
   output reg pulse
);
   initial pulse = 1'b0;
   // Levels of 500 cycles outlast the 60 kHz filter
   always @(posedge go)
   begin
      repeat (nPulse)
      begin
         repeat (500) @(negedge mclk);
         pulse = 1'b1;
         repeat (500) @(negedge mclk);
         pulse = 1'b0;
      end
   end
endmodule // fcl_pulse_src
